// *** rtl/eeprom_pkg.sv ***
package eeprom_pkg;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam int BIT_PROT_EN = 7;
    localparam int BIT_BP_HI = 3;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_WEL = 1;
    localparam int BIT_BUSY = 0;
    localparam int ADDR_W = 13;
    localparam int PAGE_BITS = 5;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam logic [2:0] NV_RESET = 3'h0;
    localparam logic [12:0] PROT_QTR_BASE = 13'h1800;
    localparam logic [12:0] PROT_HALF_BASE = 13'h1000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TWC_MS = 5;
    localparam int TWC_CYCLES = TWC_MS * 1000000 / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_ADDR = 3'b001,
        ST_WDATA = 3'b010,
        ST_RDATA = 3'b011,
        ST_STAT = 3'b100,
        ST_SKIP = 3'b101
    } phase_t;
    typedef struct packed {
        logic prot_en;
        logic bp_hi;
        logic bp_lo;
    } nv_status_t;
    typedef struct packed {
        logic start;
        logic abort;
        logic status;
        logic [12:0] addr;
    } wr_evt_t;
endpackage

// *** rtl/serial_eeprom_select_protect.sv ***
// Functional notes
// - Chip select low selects; high deselects and enters standby once no write cycle runs.
// - A started write cycle runs to its end regardless of chip select.
// - Standby with select high is entered only once the write cycle ends.
// - Serial output is released to high impedance whenever deselected.
// - Write cycle begins on select rising after a complete valid write.
// - After reset nothing is accepted until a select falling edge.
// - Read data changes only after serial clock falling edges, one bit each.
// - Internal write cycle lasts at most 5 ms.
// - Pin low with protect enable set refuses status writes only.
// - Pin high allows every function including status writes.
// - Pin low anytime during a status write aborts it when enabled.
// - Pin falling after the write cycle starts leaves that cycle alone.
// - Protect enable clear means the pin is ignored entirely.
// - Serial input bits are sampled on serial clock rising edges.
// - Status: protect enable 7, block protect 3 and 2, latch 1, busy 0.
// - Busy flag reads one during a write cycle, zero otherwise.
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // byte_fifo

module serial_eeprom_select_protect import eeprom_pkg::*; #(
    parameter int WRITE_CYCLES = TWC_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI,
    input wire logic WP_N,
    output logic SO,
    output logic SO_OE,
    output logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] RD_DATA,
    output logic [DATA_W-1:0] WR_BYTE,
    output logic WR_VALID,
    input wire logic WR_READY,
    output wr_evt_t WR_EVT,
    output logic [7:0] STATUS,
    output logic SELECTED,
    output logic STANDBY,
    output logic BUSY
);
    localparam int CW = $clog2(WRITE_CYCLES + 1);
    logic [1:0] cs_s, sck_s, si_s, wp_s;
    logic cs_d, sck_d;
    logic sck_rise, sck_fall, cs_fall, cs_rise;
    logic armed, active;
    logic [2:0] settle;
    phase_t phase;
    logic [7:0] op, shift, new_byte, out_sh;
    logic [2:0] bitcnt, obit, nbytes;
    logic byte_done;
    logic [ADDR_W-1:0] addr, start_addr;
    nv_status_t nv, staged;
    logic write_enable_latch, busy, wp_seen, ovf, so_q, out_en;
    logic [CW-1:0] busy_cnt;
    logic fifo_ready, push, complete, wr_blocked, bp_hit, array_ok, status_ok, seq_end;

    // two-flop synchronisers; first stage read only by the second
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            cs_s <= 2'h3;
            sck_s <= 2'h0;
            si_s <= 2'h0;
            wp_s <= 2'h3;
            cs_d <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            cs_s <= {cs_s[0], CS_N};
            sck_s <= {sck_s[0], SCK};
            si_s <= {si_s[0], SI};
            wp_s <= {wp_s[0], WP_N};
            cs_d <= cs_s[1];
            sck_d <= sck_s[1];
        end
    end
    assign sck_rise = sck_s[1] & ~sck_d;
    assign sck_fall = ~sck_s[1] & sck_d;
    assign cs_fall = ~cs_s[1] & cs_d;
    assign cs_rise = cs_s[1] & ~cs_d;
    assign active = armed & ~cs_s[1];
    assign new_byte = {shift[6:0], si_s[1]};
    assign byte_done = active & sck_rise & (bitcnt == 3'h7);
    assign push = byte_done & (phase == ST_WDATA) & (op == OP_WRITE);

    // power-up lockout until the first select fall; a select already low
    // at release looks like a fall to the synchroniser, so the first three
    // cycles after release cannot arm
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            armed <= 1'b0;
            settle <= 3'h0;
        end else begin
            settle <= {settle[1:0], 1'b1};
            if (cs_fall && settle[2]) begin
                armed <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN || !active) begin
            bitcnt <= 3'h0;
            shift <= 8'h00;
        end else if (sck_rise) begin
            bitcnt <= bitcnt + 3'h1;
            shift <= new_byte;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN || !active) begin
            phase <= ST_CMD;
            nbytes <= 3'h0;
            op <= 8'h00;
        end else if (byte_done) begin
            nbytes <= (nbytes == 3'h7) ? nbytes : nbytes + 3'h1;
            case (phase)
                ST_CMD: begin
                    op <= new_byte;
                    if (new_byte == OP_READ || new_byte == OP_WRITE) begin
                        phase <= ST_ADDR;
                    end else if (new_byte == OP_RDSR) begin
                        phase <= ST_STAT;
                    end else if (new_byte == OP_WRSR) begin
                        phase <= ST_WDATA;
                    end else begin
                        phase <= ST_SKIP;
                    end
                end
                ST_ADDR: begin
                    if (nbytes == 3'h2) begin
                        // array is unreadable while a write cycle runs
                        if (op == OP_WRITE) begin
                            phase <= ST_WDATA;
                        end else begin
                            phase <= busy ? ST_SKIP : ST_RDATA;
                        end
                    end
                end
                ST_WDATA, ST_RDATA, ST_STAT, ST_SKIP: phase <= phase;
                default: phase <= ST_SKIP;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            addr <= '0;
            start_addr <= '0;
            staged <= NV_RESET;
        end else if (byte_done) begin
            if (phase == ST_ADDR && nbytes == 3'h1) begin
                addr[12:8] <= new_byte[4:0];
            end else if (phase == ST_ADDR) begin
                addr[7:0] <= new_byte;
                start_addr <= {addr[12:8], new_byte};
            end else if (push) begin
                // page writes wrap inside the page
                addr[PAGE_BITS-1:0] <= addr[PAGE_BITS-1:0] + 5'h01;
            end else if (phase == ST_RDATA) begin
                addr <= addr + 13'h0001;
            end else if (phase == ST_WDATA && nbytes == 3'h1) begin
                staged <= '{new_byte[BIT_PROT_EN], new_byte[BIT_BP_HI], new_byte[BIT_BP_LO]};
            end
        end
    end

    // a byte that finds the fifo full spoils the whole write sequence
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            ovf <= 1'b0;
            wp_seen <= 1'b0;
        end else begin
            // set wins over the clear, so a pin low in the select-fall cycle counts
            if (cs_fall) begin
                ovf <= 1'b0;
                wp_seen <= 1'b0;
            end
            if (push && !fifo_ready) begin
                ovf <= 1'b1;
            end
            if (active && !wp_s[1]) begin
                wp_seen <= 1'b1;
            end
        end
    end

    byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(new_byte),
        .out_valid(WR_VALID),
        .out_ready(WR_READY),
        .out_data(WR_BYTE)
    );

    assign complete = bitcnt == 3'h0;
    assign seq_end = cs_rise & armed;
    assign wr_blocked = nv.prot_en & (wp_seen | ~wp_s[1]);
    always_comb begin
        case ({nv.bp_hi, nv.bp_lo})
            2'b01: bp_hit = start_addr >= PROT_QTR_BASE;
            2'b10: bp_hit = start_addr >= PROT_HALF_BASE;
            2'b11: bp_hit = 1'b1;
            default: bp_hit = 1'b0;
        endcase
    end
    assign array_ok = (op == OP_WRITE) & (phase == ST_WDATA) & complete & (nbytes >= 3'h4)
                      & write_enable_latch & ~busy & ~ovf & ~bp_hit;
    assign status_ok = (op == OP_WRSR) & (phase == ST_WDATA) & complete & (nbytes == 3'h2)
                       & write_enable_latch & ~busy & ~wr_blocked;

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            nv <= NV_RESET;
        end else if (seq_end && status_ok) begin
            nv <= staged;
        end
    end

    // write cycle timer, deaf to select and protect pin once started
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            busy <= 1'b0;
            busy_cnt <= '0;
        end else if (busy) begin
            busy_cnt <= busy_cnt - 1'b1;
            if (busy_cnt == '0) begin
                busy <= 1'b0;
            end
        end else if (seq_end && (array_ok || status_ok)) begin
            busy <= 1'b1;
            busy_cnt <= CW'(WRITE_CYCLES - 1);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            write_enable_latch <= 1'b0;
        end else if (busy && busy_cnt == '0) begin
            write_enable_latch <= 1'b0;
        end else if (seq_end && nbytes == 3'h1 && complete && op == OP_WREN) begin
            write_enable_latch <= 1'b1;
        end else if (seq_end && nbytes == 3'h1 && complete && op == OP_WRDI) begin
            write_enable_latch <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            WR_EVT <= '0;
        end else begin
            WR_EVT.start <= seq_end & (array_ok | status_ok);
            WR_EVT.abort <= seq_end & (op == OP_WRITE || op == OP_WRSR)
                            & (phase == ST_WDATA) & ~array_ok & ~status_ok;
            WR_EVT.status <= op == OP_WRSR;
            WR_EVT.addr <= start_addr;
        end
    end

    // serial output shifts on falling edges only
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN || !active) begin
            so_q <= 1'b0;
            out_en <= 1'b0;
            obit <= 3'h0;
            out_sh <= 8'h00;
        end else if (sck_fall && (phase == ST_RDATA || phase == ST_STAT)) begin
            out_en <= 1'b1;
            obit <= obit + 3'h1;
            if (obit == 3'h0) begin
                so_q <= (phase == ST_STAT) ? STATUS[7] : RD_DATA[7];
                out_sh <= (phase == ST_STAT) ? {STATUS[6:0], 1'b0} : {RD_DATA[6:0], 1'b0};
            end else begin
                so_q <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    assign STATUS = {nv.prot_en, 3'h0, nv.bp_hi, nv.bp_lo, write_enable_latch, busy};
    assign SO = so_q;
    assign SO_OE = out_en;
    assign ADDR = addr;
    assign BUSY = busy;
    assign SELECTED = active;
    assign STANDBY = cs_s[1] & ~busy;

    logic [CW:0] busy_age;
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN || !busy) begin
            busy_age <= '0;
        end else begin
            busy_age <= busy_age + 1'b1;
        end
    end

    sequence s_write_end;
        seq_end && (array_ok || status_ok);
    endsequence
    sequence s_busy_run;
        busy[*8];
    endsequence
    property p_deselect_hiz;
        @(posedge CLK_SYS) disable iff (!RSTN) !active |=> !SO_OE;
    endproperty
    a_deselect_hiz: assert property (p_deselect_hiz) else $error("output driven while deselected");
    property p_standby;
        @(posedge CLK_SYS) disable iff (!RSTN) busy |-> !STANDBY && !$past(STANDBY && busy);
    endproperty
    a_standby: assert property (p_standby) else $error("standby during write cycle");
    property p_write_start;
        @(posedge CLK_SYS) disable iff (!RSTN) s_write_end |=> busy && WR_EVT.start ##1 s_busy_run;
    endproperty
    a_write_start: assert property (p_write_start) else $error("write cycle not started");
    property p_busy_len;
        @(posedge CLK_SYS) disable iff (!RSTN) $fell(busy) |-> $past(busy_age) == WRITE_CYCLES - 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    property p_busy_hold;
        @(posedge CLK_SYS) disable iff (!RSTN) $rose(busy) |-> s_busy_run;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("write cycle cut short");
    property p_so_fall;
        @(posedge CLK_SYS) disable iff (!RSTN) $changed(so_q) && active |-> $past(sck_fall);
    endproperty
    a_so_fall: assert property (p_so_fall) else $error("output moved off falling edge");
    property p_lockout;
        @(posedge CLK_SYS) disable iff (!RSTN) !armed |-> phase == ST_CMD && bitcnt == 3'h0;
    endproperty
    a_lockout: assert property (p_lockout) else $error("accepted bits before select fall");
    property p_sample;
        @(posedge CLK_SYS) disable iff (!RSTN)
            active && sck_rise |=> shift[0] == $past(si_s[1]);
    endproperty
    a_sample: assert property (p_sample) else $error("input not sampled on rising edge");
    property p_protect;
        @(posedge CLK_SYS) disable iff (!RSTN)
            seq_end && op == OP_WRSR && wr_blocked |=> nv == $past(nv) && !$rose(busy);
    endproperty
    a_protect: assert property (p_protect) else $error("protected status write accepted");
    property p_busy_flag;
        @(posedge CLK_SYS) disable iff (!RSTN) $rose(STATUS[0]) |-> $past(seq_end, 1);
    endproperty
    a_busy_flag: assert property (p_busy_flag) else $error("busy flag without write start");
endmodule // serial_eeprom_select_protect

// *** verif/spi_host_model.sv ***
`timescale 1ns/10ps
module spi_host_model #(
    parameter bit START_LOW = 1'b0
) (
    input wire logic clk,
    input wire logic so,
    output logic cs_n,
    output logic sck,
    output logic si
);
    // start low only to show the lockout; then no fall before the first frame
    initial begin
        cs_n = START_LOW ? 1'b0 : 1'b1;
        sck = 1'b0;
        si = 1'b1;
    end
    task automatic open_frame();
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck <= 1'b0;
            si <= tx[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            rx[i] = so;
        end
    endtask
    task automatic close_frame();
        sck <= 1'b0;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        // released line must not keep showing the last bit
        si <= ~si;
        repeat (12) @(posedge clk);
    endtask
endmodule // spi_host_model

// *** verif/tb_serial_eeprom_select_protect.sv ***
`timescale 1ns/10ps
module tb_serial_eeprom_select_protect;
    import eeprom_pkg::*;
    // long enough for a status read to land inside the write cycle
    localparam int WC = 200;
    logic clk, rstn, wp_n, wr_ready, so, so_oe, wr_valid, cs_n, sck, si;
    logic selected, standby, busy;
    logic stall = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [7:0] rd_data, wr_byte, status, rx;
    logic [7:0] nv = 8'h00;
    logic [31:0] seed = 32'h0000005F;
    wr_evt_t evt, last_evt;
    int fails = 0, tests_run = 0, cycles = 0, busy_len = 0, max_busy = 0;
    int n_start = 0, n_abort = 0;
    logic [7:0] popped[$];

    serial_eeprom_select_protect #(.WRITE_CYCLES(WC)) dut (
        .CLK_SYS(clk), .RSTN(rstn), .CS_N(cs_n), .SCK(sck), .SI(si), .WP_N(wp_n),
        .SO(so), .SO_OE(so_oe), .ADDR(addr), .RD_DATA(rd_data), .WR_BYTE(wr_byte),
        .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_EVT(evt), .STATUS(status),
        .SELECTED(selected), .STANDBY(standby), .BUSY(busy));
    // a released output floats to its pull-up
    spi_host_model #(.START_LOW(1'b1)) host (
        .clk(clk), .so(so_oe ? so : 1'b1), .cs_n(cs_n), .sck(sck), .si(si));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [7:0] pat(input logic [12:0] a);
        return a[7:0] ^ {3'h5, a[12:8]};
    endfunction
    // array answers at once, so the first fall of a byte sees it
    always_comb rd_data = pat(addr);
    always @(posedge clk) begin
        cycles <= cycles + 1;
        seed <= xs(seed);
        wr_ready <= stall ? 1'b0 : seed[3];
        if (evt.start) n_start++;
        if (evt.abort) n_abort++;
        if (evt.start || evt.abort) last_evt <= evt;
        if (wr_valid && wr_ready) popped.push_back(wr_byte);
        busy_len <= busy ? busy_len + 1 : 0;
        if (busy && busy_len + 1 > max_busy) max_busy <= busy_len + 1;
        if (cycles == 40000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        host.open_frame();
        host.xbyte(op, rx);
        host.close_frame();
    endtask
    task automatic rdsr(input logic [7:0] exp, m);
        host.open_frame();
        host.xbyte(OP_RDSR, rx);
        host.xbyte(8'h00, rx);
        check("so_oe_sel", so_oe, 1'b1);
        check("selected", selected, 1'b1);
        host.close_frame();
        check("so_oe_desel", so_oe, 1'b0);
        check("status", rx & m, exp);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        check("idle", busy, 1'b0);
    endtask
    task automatic wr_page(input int n, input logic ok);
        logic [12:0] a;
        logic [7:0] d[$];
        int s0, ab0, m;
        cmd(OP_WREN);
        a = seed[12:0];
        popped.delete();
        stall <= (n > 32);
        s0 = n_start;
        ab0 = n_abort;
        host.open_frame();
        host.xbyte(OP_WRITE, rx);
        host.xbyte({3'h0, a[12:8]}, rx);
        host.xbyte(a[7:0], rx);
        for (int k = 0; k < n; k++) begin
            d.push_back(seed[15:8]);
            host.xbyte(d[k], rx);
        end
        host.close_frame();
        check("wr_start", n_start - s0, {31'h0, ok});
        check("wr_abort", n_abort - ab0, {31'h0, !ok});
        check("evt_status", last_evt.status, 1'b0);
        if (ok) begin
            check("standby_busy", standby, 1'b0);
            check("evt_addr", last_evt.addr, a);
            rdsr(8'h03, 8'hFF);
            check("busy_held", busy, 1'b1);
            wait_idle();
            check("busy_len", max_busy, WC);
            check("standby_idle", standby, 1'b1);
            rdsr(8'h00, 8'hFF);
        end
        stall <= 1'b0;
        m = n > 32 ? 32 : n;
        for (int i = 0; i < 800 && popped.size() < m; i++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        check("fifo_count", popped.size(), m);
        for (int k = 0; k < m && k < popped.size(); k++)
            check("fifo_byte", popped[k], d[k]);
        check("fifo_empty", wr_valid, 1'b0);
    endtask
    task automatic rd2(input logic [12:0] a);
        host.open_frame();
        host.xbyte(OP_READ, rx);
        host.xbyte({3'h0, a[12:8]}, rx);
        host.xbyte(a[7:0], rx);
        host.xbyte(8'h00, rx);
        check("rd0", rx, pat(a));
        host.xbyte(8'h00, rx);
        check("rd1", rx, pat(a + 13'h1));
        host.close_frame();
    endtask
    task automatic wrsr(input logic [7:0] v, input logic wa, wb, wc, ok);
        int s0;
        cmd(OP_WREN);
        wp_n <= wa;
        s0 = n_start;
        host.open_frame();
        host.xbyte(OP_WRSR, rx);
        wp_n <= wb;
        host.xbyte(v, rx);
        wp_n <= wa;
        host.close_frame();
        // pin falls while the cycle runs in one case; it must finish anyway
        wp_n <= wc;
        check("wrsr_ok", n_start - s0, {31'h0, ok});
        check("evt_status", last_evt.status, 1'b1);
        wait_idle();
        if (ok) nv = v & 8'h8C;
        rdsr(nv, 8'h8D);
    endtask

    initial begin
        rstn = 1'b0;
        wp_n = 1'b1;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check("status_rst", status, 8'h00);
        check("standby_rst", standby, 1'b1);
        host.open_frame();
        host.xbyte(OP_WREN, rx);
        check("locked", selected, 1'b0);
        host.close_frame();
        rdsr(8'h00, 8'hFF);
        cmd(OP_WREN);
        rdsr(8'h02, 8'hFF);
        cmd(OP_WRDI);
        rdsr(8'h00, 8'hFF);
        wr_page(3, 1'b1);
        wr_page(33, 1'b0);
        rd2(13'h1FFF);
        rd2(seed[12:0]);
        wrsr(8'h80, 1'b0, 1'b0, 1'b0, 1'b1);
        wrsr(8'h0C, 1'b0, 1'b0, 1'b0, 1'b0);
        wrsr(8'h0C, 1'b1, 1'b0, 1'b1, 1'b0);
        wrsr(8'h8C, 1'b1, 1'b1, 1'b0, 1'b1);
        // whole array block-protected now: an array write must be refused
        wr_page(1, 1'b0);
        wrsr(8'h00, 1'b1, 1'b1, 1'b1, 1'b1);
        report_and_stop();
    end
endmodule // tb_serial_eeprom_select_protect
